//--- rtl/acr_regs.sv
// Behaviour
// - Channel 2 impedance code 0/1/2 selects 2.5k/10k/20k ohm; 3 reserved.
// - Channel 2 AGC bit enables AGC, qualified by global AGC bit 3.
// - Six-bit channel 2 gain in bits 7..2, 1 dB steps, 0 to 42.
// - Volume code 0 mutes; 1 is -100 dB, 0.5 dB steps, 201 is 0 dB.
// - Volume resets to unity code so the channel passes at 0 dB.
// - Gain trim bits 7..4 in 0.1 dB steps; reset code 8 is 0 dB.
// - Phase trim delays the channel by its code in modulator cycles.
// - Channel 2 config 1..4 and channel 3 config 0 sit at consecutive addresses.
// - Channel 3 bit 7 selects microphone at 0, line at 1; resets 0.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module acr_regs (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [acr_pkg::ACR_AW-1:0]  paddr,
  input  wire logic [acr_pkg::ACR_DW-1:0]  pwdata,
  output logic                             pready,
  output logic [acr_pkg::ACR_DW-1:0]       prdata,
  output logic                             pslverr,
  input  wire logic                        ch2_mod_bit,
  output logic                             ch2_mod_bit_dly,
  output logic [1:0]                       ch2_input_impedance_sel,
  output logic                             ch2_auto_gain_on,
  output logic [5:0]                       ch2_front_gain,
  output logic [7:0]                       ch2_volume_code,
  output logic                             ch2_mute,
  output logic [3:0]                       ch2_front_gain_trim_code,
  output logic [7:0]                       ch2_phase_delay_code,
  output logic                             ch3_line_not_mic,
  output logic [1:0]                       ch3_input_source,
  output logic                             coupling_a,
  output logic [1:0]                       ch3_input_impedance_sel,
  output logic                             ch3_auto_gain_on
);
  import acr_pkg::*;

  acr_rf_if rf ();

  acr_apb_st_t                 st_q;
  logic                        setup;
  logic                        access;
  logic                        hit;
  logic [$clog2(ACR_NREG)-1:0] slot;
  logic [ACR_AW-1:0]           slot_addr;
  logic [3:0]                  mod_cnt_q;
  logic                        mod_tick;

  // ==========================================================================
  // APB phase tracking
  assign setup  = psel && !penable;
  assign access = psel && penable && (st_q == ACR_ACCESS);

  // Zero wait states: every access phase completes in its first cycle.
  assign pready = (st_q == ACR_ACCESS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ACR_IDLE;
    end else begin
      unique case (st_q)
        ACR_IDLE: begin
          if (setup) begin
            st_q <= ACR_ACCESS;
          end
        end
        ACR_ACCESS: begin
          st_q <= ACR_IDLE;
        end
        default: begin
          st_q <= ACR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Address decode
  // Only word-aligned byte addresses match; anything else is unmapped.
  always_comb begin
    hit       = 1'b0;
    slot      = '0;
    slot_addr = '0;
    for (int i = 0; i < ACR_NREG; i++) begin
      slot_addr = {2'b00, ACR_SLOT_IDX[i], 2'b00};
      if (paddr == slot_addr) begin
        hit  = 1'b1;
        slot = ($clog2(ACR_NREG))'(i);
      end
    end
  end

  // ==========================================================================
  // Write path
  assign rf.wdata = pwdata[ACR_BW-1:0];

  always_comb begin
    rf.wsel = '0;
    if (access && pwrite && hit) begin
      rf.wsel[slot] = 1'b1;
    end
  end

  // ==========================================================================
  // Register storage
  for (genvar g = 0; g < ACR_NREG; g++) begin : g_reg
    acr_cfg_reg #(
      .SLOT (g),
      .MASK (ACR_SLOT_MASK[g]),
      .RST  (ACR_SLOT_RST[g])
    ) u_reg (
      .pclk    (pclk),
      .presetn (presetn),
      .rf      (rf)
    );
  end

  // ==========================================================================
  // Read path
  // Read data is captured in the setup cycle so prdata comes from a flop
  // and is stable for the whole access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= hit ? {24'h00_0000, rf.q[slot]} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !hit;
    end
  end

  // ==========================================================================
  // Field outputs
  assign ch2_input_impedance_sel =
    rf.q[ACR_SLOT_IN2][ACR_IMP_LSB +: 2];
  // AGC runs only when both the channel bit and the global bit are set.
  assign ch2_auto_gain_on = rf.q[ACR_SLOT_IN2][ACR_AGC_BIT]
                         && rf.q[ACR_SLOT_GLOB][ACR_GLOB_AGC_BIT];
  assign ch2_front_gain       = rf.q[ACR_SLOT_GAIN][ACR_GAIN_LSB +: 6];
  assign ch2_volume_code      = rf.q[ACR_SLOT_VOL];
  assign ch2_mute             = (rf.q[ACR_SLOT_VOL] == ACR_VOL_MUTE);
  assign ch2_front_gain_trim_code   = rf.q[ACR_SLOT_TRIM][ACR_TRIM_LSB +: 4];
  assign ch2_phase_delay_code = rf.q[ACR_SLOT_PHASE];
  assign ch3_line_not_mic     = rf.q[ACR_SLOT_IN3][ACR_LINE_BIT];
  assign ch3_input_source     = rf.q[ACR_SLOT_IN3][ACR_SRC_LSB +: 2];
  assign coupling_a           = rf.q[ACR_SLOT_IN3][ACR_DC_BIT];
  assign ch3_input_impedance_sel = rf.q[ACR_SLOT_IN3][ACR_IMP_LSB +: 2];
  assign ch3_auto_gain_on = rf.q[ACR_SLOT_IN3][ACR_AGC_BIT]
                         && rf.q[ACR_SLOT_GLOB][ACR_GLOB_AGC_BIT];

  // ==========================================================================
  // Modulator clock enable and phase trim
  // The modulator rate is a fixed division of pclk, so the delay resolution
  // is one enable period, not one pclk cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_cnt_q <= 4'h0;
    end else if (mod_tick) begin
      mod_cnt_q <= 4'h0;
    end else begin
      mod_cnt_q <= mod_cnt_q + 4'h1;
    end
  end

  assign mod_tick = (mod_cnt_q == ACR_MOD_LAST);

  acr_phase_delay u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (mod_tick),
    .din     (ch2_mod_bit),
    .delay   (ch2_phase_delay_code),
    .dout    (ch2_mod_bit_dly)
  );

  // ==========================================================================
  // Checks
  logic wr_fire;
  assign wr_fire = psel && penable && pready && pwrite;

  property p_imp_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_INPUT, 2'b00}
    |=> ch2_input_impedance_sel == $past(pwdata[ACR_IMP_LSB +: 2]);
  endproperty
  a_imp_write: assert property (p_imp_write)
    else $error("Impedance select did not follow the write.");

  // Tied to the written bit, so a broken gate or a lost write both show.
  property p_agc_gate;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_INPUT, 2'b00}
    |=> ch2_auto_gain_on == ($past(pwdata[ACR_AGC_BIT])
                          && rf.q[ACR_SLOT_GLOB][ACR_GLOB_AGC_BIT]);
  endproperty
  a_agc_gate: assert property (p_agc_gate)
    else $error("AGC on without both enable bits.");

  property p_gain_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_FRONT_GAIN, 2'b00}
    |=> ch2_front_gain == $past(pwdata[ACR_GAIN_LSB +: 6]);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("Channel gain did not follow the write.");

  property p_mute;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_VOL, 2'b00}
    |=> ch2_mute == ($past(pwdata[7:0]) == ACR_VOL_MUTE);
  endproperty
  a_mute: assert property (p_mute)
    else $error("Mute does not match the written volume code.");

  property p_vol_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ch2_volume_code == ACR_VOL_UNITY;
  endproperty
  a_vol_reset: assert property (p_vol_reset)
    else $error("Volume is not at unity after reset.");

  property p_trim_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_TRIM, 2'b00}
    |=> ch2_front_gain_trim_code == $past(pwdata[ACR_TRIM_LSB +: 4]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("Gain trim did not follow the write.");

  property p_trim_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> ch2_front_gain_trim_code == ACR_TRIM_ZERO;
  endproperty
  a_trim_reset: assert property (p_trim_reset)
    else $error("Gain trim is not at zero dB after reset.");

  property p_read_gain;
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == {2'b00, ACR_IDX_CH2_FRONT_GAIN, 2'b00}
    |=> prdata == {24'h00_0000, ch2_front_gain, 2'b00} && !pslverr;
  endproperty
  a_read_gain: assert property (p_read_gain)
    else $error("Gain register read back wrong.");

  property p_line_write;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH3_INPUT, 2'b00}
    |=> ch3_line_not_mic == $past(pwdata[ACR_LINE_BIT]);
  endproperty
  a_line_write: assert property (p_line_write)
    else $error("Input type did not follow the write.");

  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite |-> prdata[ACR_DW-1:ACR_BW] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Read data above bit 7 is not zero.");

  property p_one_cycle_wait;
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready;
  endproperty
  a_one_cycle_wait: assert property (p_one_cycle_wait)
    else $error("Access phase did not complete at once.");

  c_write_vol: cover property (@(posedge pclk) disable iff (!presetn)
    wr_fire && paddr == {2'b00, ACR_IDX_CH2_VOL, 2'b00});
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
  c_delay_max: cover property (@(posedge pclk) disable iff (!presetn)
    mod_tick && ch2_phase_delay_code == 8'hFF);

endmodule
`default_nettype wire

//--- rtl/acr_pkg.sv
`default_nettype none
package acr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ACR_AW = 12;
  localparam int unsigned ACR_DW = 32;
  localparam int unsigned ACR_BW = 8;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] ACR_IDX_CH2_INPUT = 8'h41;
  localparam logic [7:0] ACR_IDX_CH2_FRONT_GAIN  = 8'h42;
  localparam logic [7:0] ACR_IDX_CH2_VOL   = 8'h43;
  localparam logic [7:0] ACR_IDX_CH2_TRIM  = 8'h44;
  localparam logic [7:0] ACR_IDX_CH2_PHASE = 8'h45;
  localparam logic [7:0] ACR_IDX_CH3_INPUT = 8'h46;
  localparam logic [7:0] ACR_IDX_GLOB_AGC  = 8'h6C;

  // ==========================================================================
  // Storage slots
  localparam int unsigned ACR_NREG       = 7;
  localparam int unsigned ACR_SLOT_IN2   = 0;
  localparam int unsigned ACR_SLOT_GAIN  = 1;
  localparam int unsigned ACR_SLOT_VOL   = 2;
  localparam int unsigned ACR_SLOT_TRIM  = 3;
  localparam int unsigned ACR_SLOT_PHASE = 4;
  localparam int unsigned ACR_SLOT_IN3   = 5;
  localparam int unsigned ACR_SLOT_GLOB  = 6;

  localparam logic [7:0] ACR_SLOT_IDX [ACR_NREG] = '{
    ACR_IDX_CH2_INPUT, ACR_IDX_CH2_FRONT_GAIN, ACR_IDX_CH2_VOL, ACR_IDX_CH2_TRIM,
    ACR_IDX_CH2_PHASE, ACR_IDX_CH3_INPUT, ACR_IDX_GLOB_AGC};
  // Writable bits; everything else is reserved and reads as zero.
  localparam logic [7:0] ACR_SLOT_MASK [ACR_NREG] = '{
    8'h0D, 8'hFC, 8'hFF, 8'hF0, 8'hFF, 8'hFD, 8'h08};
  localparam logic [7:0] ACR_SLOT_RST [ACR_NREG] = '{
    8'h00, 8'h00, 8'hC9, 8'h80, 8'h00, 8'h00, 8'h00};

  // ==========================================================================
  // Field positions and codes
  localparam int unsigned ACR_AGC_BIT      = 0;
  localparam int unsigned ACR_IMP_LSB      = 2;
  localparam int unsigned ACR_DC_BIT       = 4;
  localparam int unsigned ACR_SRC_LSB      = 5;
  localparam int unsigned ACR_LINE_BIT     = 7;
  localparam int unsigned ACR_GAIN_LSB     = 2;
  localparam int unsigned ACR_TRIM_LSB     = 4;
  localparam int unsigned ACR_GLOB_AGC_BIT = 3;
  localparam logic [7:0]  ACR_VOL_MUTE     = 8'h00;
  localparam logic [7:0]  ACR_VOL_UNITY    = 8'hC9;
  localparam logic [3:0]  ACR_TRIM_ZERO    = 4'h8;

  // ==========================================================================
  // Modulator clock enable and phase delay line
  localparam logic [3:0]  ACR_MOD_LAST  = 4'h7;
  localparam int unsigned ACR_DLY_DEPTH = 256;

  typedef enum logic [1:0] {
    ACR_IDLE   = 2'b01,
    ACR_ACCESS = 2'b10
  } acr_apb_st_t;

endpackage
`default_nettype wire

//--- rtl/acr_rf_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acr_rf_if;
  import acr_pkg::*;
  logic [7:0]          wdata;
  logic [ACR_NREG-1:0] wsel;
  logic [7:0]          q [ACR_NREG];
  modport host  (output wdata, output wsel, input q);
  modport store (input wdata, input wsel, output q);
endinterface
`default_nettype wire

//--- rtl/acr_cfg_reg.sv
`timescale 1ns/100ps
`default_nettype none
module acr_cfg_reg #(
  parameter int unsigned SLOT = 0,
  parameter logic [7:0]  MASK = 8'hFF,
  parameter logic [7:0]  RST  = 8'h00
) (
  input wire logic   pclk,
  input wire logic   presetn,
  acr_rf_if.store    rf
);
  logic [7:0] val_q;

  // ==========================================================================
  // Storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= RST;
    end else if (rf.wsel[SLOT]) begin
      val_q <= rf.wdata & MASK;
    end
  end

  assign rf.q[SLOT] = val_q;

  // ==========================================================================
  // Checks
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    (val_q & ~MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved register bit is set.");

  property p_write_lands;
    @(posedge pclk) disable iff (!presetn)
    rf.wsel[SLOT] |=> val_q == ($past(rf.wdata) & MASK);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Selected register did not take the write.");

endmodule
`default_nettype wire

//--- rtl/acr_phase_delay.sv
`timescale 1ns/100ps
`default_nettype none
module acr_phase_delay (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       din,
  input  wire logic [7:0] delay,
  output logic            dout
);
  import acr_pkg::*;

  logic       mem_q [ACR_DLY_DEPTH];
  logic [7:0] wptr_q;
  logic [7:0] rd_idx;
  logic       last_din_q;

  // Reading at wptr minus delay wraps naturally in eight bits.
  assign rd_idx = wptr_q - delay;

  // ==========================================================================
  // Delay line, one slot per modulator cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ACR_DLY_DEPTH; i++) begin
        mem_q[i] <= 1'b0;
      end
    end else if (tick) begin
      mem_q[wptr_q] <= din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 8'h00;
    end else if (tick) begin
      wptr_q <= wptr_q + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 1'b0;
    end else if (tick) begin
      dout <= (delay == 8'h00) ? din : mem_q[rd_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_din_q <= 1'b0;
    end else if (tick) begin
      last_din_q <= din;
    end
  end

  // ==========================================================================
  // Checks
  property p_no_delay;
    @(posedge pclk) disable iff (!presetn)
    tick && delay == 8'h00 |=> dout == $past(din);
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("Zero phase code did not pass the sample straight.");

  property p_one_delay;
    @(posedge pclk) disable iff (!presetn)
    tick && delay == 8'h01 |=> dout == $past(last_din_q);
  endproperty
  a_one_delay: assert property (p_one_delay)
    else $error("Phase code one did not delay by one modulator cycle.");

endmodule
`default_nettype wire

//--- verif/adc_channel_config_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

`define ACR_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module adc_channel_config_regs_tb_top;
  import acr_pkg::*;

  typedef struct {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } acr_exp_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ch2_mod_bit;
  logic        ch2_mod_bit_dly;
  logic [1:0]  ch2_input_impedance_sel;
  logic        ch2_auto_gain_on;
  logic [5:0]  ch2_front_gain;
  logic [7:0]  ch2_volume_code;
  logic        ch2_mute;
  logic [3:0]  ch2_front_gain_trim_code;
  logic [7:0]  ch2_phase_delay_code;
  logic        ch3_line_not_mic;
  logic [1:0]  ch3_input_source;
  logic        coupling_a;
  logic [1:0]  ch3_input_impedance_sel;
  logic        ch3_auto_gain_on;

  int          fail_count = 0;
  int          checked    = 0;
  int          cycles     = 0;
  integer      seed       = 24632;
  acr_exp_t    exp_q[$];
  acr_exp_t    e;
  logic [7:0]  mdl [ACR_NREG];

  // Directed values: every impedance code, gain 0 and 42 with reserved bits set,
  // volume mute, minimum, unity and maximum, trim extremes, AGC on then off.
  int unsigned dir_slot [15] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 2, 3, 3, 5, 6, 6};
  logic [7:0]  dir_val  [15] = '{8'h00, 8'h04, 8'h08, 8'h0D, 8'h00, 8'hAB, 8'h00, 8'h01,
                                 8'hC9, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic [7:0]  codes    [4]  = '{8'h00, 8'h01, 8'h05, 8'hFF};

  acr_regs u_dut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pready                  (pready),
    .prdata                  (prdata),
    .pslverr                 (pslverr),
    .ch2_mod_bit             (ch2_mod_bit),
    .ch2_mod_bit_dly         (ch2_mod_bit_dly),
    .ch2_input_impedance_sel (ch2_input_impedance_sel),
    .ch2_auto_gain_on        (ch2_auto_gain_on),
    .ch2_front_gain          (ch2_front_gain),
    .ch2_volume_code         (ch2_volume_code),
    .ch2_mute                (ch2_mute),
    .ch2_front_gain_trim_code      (ch2_front_gain_trim_code),
    .ch2_phase_delay_code    (ch2_phase_delay_code),
    .ch3_line_not_mic        (ch3_line_not_mic),
    .ch3_input_source        (ch3_input_source),
    .coupling_a              (coupling_a),
    .ch3_input_impedance_sel (ch3_input_impedance_sel),
    .ch3_auto_gain_on        (ch3_auto_gain_on)
  );

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // ==========================================================================
  // Closing report and hang guard
  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Bus driver; the request is left standing so a caller may chain transfers.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp_d, input logic exp_err);
    exp_q.push_back('{rd: !wr, data: exp_d, err: exp_err});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff (pready === 1'b1));
  endtask

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [11:0] slot_addr(input int unsigned s);
    return {2'b00, ACR_SLOT_IDX[s], 2'b00};
  endfunction

  task automatic check_fields();
    @(negedge pclk);
    `ACR_CHK(ch2_input_impedance_sel, mdl[0][3:2]);
    `ACR_CHK(ch2_auto_gain_on, mdl[0][0] & mdl[6][3]);
    `ACR_CHK(ch2_front_gain, mdl[1][7:2]);
    `ACR_CHK(ch2_volume_code, mdl[2]);
    `ACR_CHK(ch2_mute, (mdl[2] == 8'h00));
    `ACR_CHK(ch2_front_gain_trim_code, mdl[3][7:4]);
    `ACR_CHK(ch2_phase_delay_code, mdl[4]);
    `ACR_CHK(ch3_line_not_mic, mdl[5][7]);
    `ACR_CHK({ch3_input_source, coupling_a}, mdl[5][6:4]);
    `ACR_CHK(ch3_input_impedance_sel, mdl[5][3:2]);
    `ACR_CHK(ch3_auto_gain_on, mdl[5][0] & mdl[6][3]);
    // Return on a rising edge so the next request is launched there.
    @(posedge pclk);
  endtask

  // Write, then read back at once in a back-to-back transfer.
  task automatic wr_slot(input int unsigned s, input logic [7:0] v);
    mdl[s] = v & ACR_SLOT_MASK[s];
    apb(1'b1, slot_addr(s), {24'($random(seed)), v}, 32'h0000_0000, 1'b0);
    apb(1'b0, slot_addr(s), 32'h0000_0000, {24'h00_0000, mdl[s]}, 1'b0);
    idle();
    check_fields();
  endtask

  task automatic phase_run(input logic [7:0] c);
    int lat;
    lat = 0;
    wr_slot(ACR_SLOT_PHASE, c);
    ch2_mod_bit <= 1'b0;
    // The delay line is fed zeros for the code plus two modulator cycles before the step.
    repeat ((int'(c) + 2) * 8) @(posedge pclk);
    `ACR_CHK(ch2_mod_bit_dly, 1'b0);
    ch2_mod_bit <= 1'b1;
    do begin
      @(posedge pclk);
      lat++;
    end while (ch2_mod_bit_dly !== 1'b1 && lat < 3000);
    `ACR_CHK((lat >= int'(c) * 8 + 1) && (lat <= int'(c) * 8 + 10), 1'b1);
  endtask

  // ==========================================================================
  // Response checker: the oldest noted expectation meets each completed transfer.
  always @(posedge pclk) begin
    if (psel && penable && pready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.rd) `ACR_CHK(prdata, e.data);
      `ACR_CHK(pslverr, e.err);
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    ch2_mod_bit = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < ACR_NREG; i++) begin
      mdl[i] = ACR_SLOT_RST[i];
      apb(1'b0, slot_addr(i), 32'h0000_0000, {24'h00_0000, mdl[i]}, 1'b0);
    end
    idle();
    check_fields();
    `ACR_CHK({ch2_volume_code, ch2_front_gain_trim_code}, 12'hC9_8);
    for (int i = 0; i < 15; i++) wr_slot(dir_slot[i], dir_val[i]);
    for (int i = 0; i < 30; i++) wr_slot($unsigned($random(seed)) % ACR_NREG, 8'($random(seed)));
    // Unmapped, below the bank and misaligned: refused, nothing stored.
    apb(1'b0, 12'h100, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h11C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h109, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    idle();
    check_fields();
    for (int i = 0; i < 4; i++) phase_run(codes[i]);
    // A second reset in mid-run restores the defaults.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < ACR_NREG; i++) mdl[i] = ACR_SLOT_RST[i];
    @(posedge pclk);
    check_fields();
    repeat (2) @(posedge pclk);
    `ACR_CHK(exp_q.size(), 0);
    finish_test();
  end

endmodule

`default_nettype wire
